// *** design/pti_target.sv ***
// pci target access path: control window, two memory windows, indirect io window
`timescale 1ns/100ps
module pti_target
    import pti_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // decoded host request, held until o_done
    input  wire logic        i_req_valid,
    input  pti_req_t         i_req,
    output logic             o_done,
    output logic             o_err,
    output logic      [31:0] o_rdata,
    // control register bus
    output logic             o_reg_req,
    output logic             o_reg_we,
    output logic      [15:0] o_reg_addr,
    output logic      [3:0]  o_reg_be,
    output logic      [31:0] o_reg_wdata,
    input  wire logic        i_reg_ack,
    input  wire logic [31:0] i_reg_rdata,
    // core memory dma port, data returns the cycle after the request
    output logic             o_mem_req,
    output logic             o_mem_we,
    output logic             o_mem_core,
    output logic             o_mem_wide,
    output logic      [15:0] o_mem_addr,
    output logic      [23:0] o_mem_wdata,
    input  wire logic [23:0] i_mem_rdata
);

    pti_state_t  state_r;
    pti_state_t  state_nxt;
    pti_cur_t    cur_r;
    pti_cur_t    cur_nxt;

    logic        done_r;
    logic        err_r;
    logic [31:0] rdata_r;
    logic        reg_req_r;
    logic        reg_we_r;
    logic [15:0] reg_addr_r;
    logic [3:0]  reg_be_r;
    logic [31:0] reg_wdata_r;
    logic        mem_req_r;
    logic        mem_we_r;
    logic        mem_core_r;
    logic        mem_wide_r;
    logic [15:0] mem_addr_r;
    logic [23:0] mem_wdata_r;

    pti_io_st_t  io_st  [PTI_NUM_FUNC];
    logic [15:0] io_rd  [PTI_NUM_FUNC];

    // request decode
    wire       take     = i_req_valid && !done_r && (state_r == PTI_ST_IDLE);
    wire       func_ok  = i_req.func <= PTI_FUNC_LAST;
    wire       win_ctrl = (i_req.win == PTI_WIN_CTRL) && !i_req.is_io;
    wire       win_m24  = (i_req.win == PTI_WIN_MEM24) && !i_req.is_io;
    wire       win_m16  = (i_req.win == PTI_WIN_MEM16) && !i_req.is_io;
    wire       win_io   = (i_req.win == PTI_WIN_IO) && i_req.is_io;
    wire       win_mem  = win_m24 || win_m16;
    wire       be_lo    = i_req.be == PTI_BE_LO16;
    wire       be_hi    = i_req.be == PTI_BE_HI16;
    wire       be_hw    = be_lo || be_hi;
    wire       be_full  = i_req.be == PTI_BE_FULL;
    wire       io_ok    = win_io && be_hw;
    wire       mem_ok   = win_mem && (be_full || be_hw);
    wire       req_ok   = func_ok && (win_ctrl || mem_ok || io_ok);
    wire [2:0] io_idx   = {i_req.addr[3:2], be_hi};
    wire [15:0] io_wd   = be_hi ? i_req.wdata[31:16] : i_req.wdata[15:0];

    // the function's indirect register set is picked once and shared by all decoding
    wire [1:0] fsel     = func_ok ? i_req.func : 2'h0;
    pti_io_st_t sel_st;
    assign sel_st = io_st[fsel];

    // io triggers: direction field decides whether a data access moves anything
    wire io_rdat  = io_ok && (io_idx == PTI_IO_REG_DATA);
    wire io_mdat  = io_ok && (io_idx == PTI_IO_MEM_DLO);
    wire go_reg_w = io_rdat && i_req.write && sel_st.reg_dir;
    wire go_reg_r = io_rdat && !i_req.write && !sel_st.reg_dir;
    wire go_mem_w = io_mdat && i_req.write && sel_st.mem_we;
    wire go_mem_r = io_mdat && !i_req.write && !sel_st.mem_we;

    wire go_reg   = (win_ctrl && func_ok) || go_reg_w || go_reg_r;
    wire go_mem   = (mem_ok && func_ok) || go_mem_w || go_mem_r;

    // direct memory window: word address and half select
    wire        dm_core = i_req.addr[PTI_MEM_HALF];
    wire [15:0] dm_addr = i_req.addr[PTI_MEM_WLSB +: 16];
    wire [23:0] dm_wd   = win_m24 ? i_req.wdata[23:0] : {8'h00, i_req.wdata[15:0]};

    // indirect register bus word: 16-bit value placed on the lane its address picks
    wire        ir_hi   = sel_st.reg_addr[1];
    wire [15:0] ir_addr = {1'b0, sel_st.reg_addr};
    wire [3:0]  ir_be   = ir_hi ? PTI_BE_HI16 : PTI_BE_LO16;
    wire [15:0] ir_wd   = go_reg_w ? io_wd : sel_st.reg_data;

    // completion data
    wire [15:0] reg_half = cur_r.hi ? i_reg_rdata[31:16] : i_reg_rdata[15:0];
    wire [23:0] mem_val  = cur_r.wide ? i_mem_rdata : {8'h00, i_mem_rdata[15:0]};
    wire        ld_reg   = (state_r == PTI_ST_REG) && i_reg_ack && cur_r.io && cur_r.rd;
    wire        ld_mem   = (state_r == PTI_ST_CAP) && cur_r.io && cur_r.rd;

    genvar gf;
    generate
        for (gf = 0; gf < PTI_NUM_FUNC; gf++) begin : g_func
            // a function's io registers only see requests addressed to it, except that function 0's also take io writes to the refused function 3
            wire sel_f = (fsel == 2'(gf));
            pti_io_regs u_io (
                .i_clk     (i_clk),
                .i_rst_n   (i_rst_n),
                .i_wr      (take && io_ok && i_req.write && sel_f),
                .i_idx     (io_idx),
                .i_wdata   (io_wd),
                .i_ld_reg  (ld_reg && (cur_r.func == 2'(gf))),
                .i_reg_val (reg_half),
                .i_ld_mem  (ld_mem && (cur_r.func == 2'(gf))),
                .i_mem_val (mem_val),
                .o_st      (io_st[gf]),
                .o_rd16    (io_rd[gf])
            );
        end
    endgenerate

    wire [15:0] io_rd_sel = io_rd[fsel];

    // next state
    always_comb begin
        state_nxt = state_r;
        cur_nxt   = cur_r;
        case (state_r)
            PTI_ST_IDLE: begin
                if (take && req_ok) begin
                    cur_nxt.func = i_req.func;
                    cur_nxt.io   = win_io;
                    cur_nxt.rd   = !i_req.write;
                    cur_nxt.hi   = win_io ? be_hi : 1'b0;
                    cur_nxt.wide = win_io ? sel_st.mem_wide : win_m24;
                    if (go_reg) begin
                        cur_nxt.hi = win_io ? ir_hi : 1'b0;
                        state_nxt  = PTI_ST_REG;
                    end else if (go_mem) begin
                        state_nxt = PTI_ST_MEM;
                    end
                end
            end
            PTI_ST_REG: begin
                if (i_reg_ack) begin
                    state_nxt = PTI_ST_IDLE;
                end
            end
            PTI_ST_MEM: begin
                state_nxt = PTI_ST_CAP;
            end
            PTI_ST_CAP: begin
                state_nxt = PTI_ST_IDLE;
            end
            default: begin
                state_nxt = PTI_ST_IDLE;
            end
        endcase
    end

    // completion pulse: io register-only accesses finish at once, transfers wait
    wire fin_now = take && (!req_ok || (!go_reg && !go_mem));
    wire fin_reg = (state_r == PTI_ST_REG) && i_reg_ack;
    wire fin_mem = state_r == PTI_ST_CAP;
    wire done_nxt = fin_now || fin_reg || fin_mem;

    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = rdata_r;
        if (fin_now) begin
            rdata_nxt = (req_ok && win_io && !i_req.write) ? {io_rd_sel, io_rd_sel}
                                                            : PTI_RST_WORD;
        end else if (fin_reg) begin
            rdata_nxt = cur_r.io ? {reg_half, reg_half} : i_reg_rdata;
        end else if (fin_mem) begin
            rdata_nxt = cur_r.io ? {mem_val[15:0], mem_val[15:0]} : {8'h00, mem_val};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= PTI_ST_IDLE;
            cur_r   <= '0;
            done_r  <= 1'b0;
            err_r   <= 1'b0;
            rdata_r <= PTI_RST_WORD;
        end else begin
            state_r <= state_nxt;
            cur_r   <= cur_nxt;
            done_r  <= done_nxt;
            err_r   <= fin_now && !req_ok;
            rdata_r <= rdata_nxt;
        end
    end

    // control register bus: request held until acknowledged
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            reg_req_r   <= 1'b0;
            reg_we_r    <= 1'b0;
            reg_addr_r  <= PTI_RST_HW;
            reg_be_r    <= 4'h0;
            reg_wdata_r <= PTI_RST_WORD;
        end else if (take && req_ok && go_reg) begin
            reg_req_r   <= 1'b1;
            reg_we_r    <= win_io ? go_reg_w : i_req.write;
            reg_addr_r  <= win_io ? ir_addr : i_req.addr[15:0];
            reg_be_r    <= win_io ? ir_be : i_req.be;
            reg_wdata_r <= win_io ? {ir_wd, ir_wd} : i_req.wdata;
        end else if (i_reg_ack) begin
            reg_req_r <= 1'b0;
        end
    end

    // core memory port: exactly one request cycle per host word
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mem_req_r   <= 1'b0;
            mem_we_r    <= 1'b0;
            mem_core_r  <= 1'b0;
            mem_wide_r  <= 1'b0;
            mem_addr_r  <= PTI_RST_HW;
            mem_wdata_r <= PTI_RST_MDATA;
        end else begin
            mem_req_r <= take && req_ok && !go_reg && go_mem;
            if (take && req_ok && !go_reg && go_mem) begin
                mem_we_r    <= win_io ? go_mem_w : i_req.write;
                mem_core_r  <= win_io ? sel_st.mem_core : dm_core;
                mem_wide_r  <= win_io ? sel_st.mem_wide : win_m24;
                mem_addr_r  <= win_io ? sel_st.mem_addr : dm_addr;
                mem_wdata_r <= win_io ? {sel_st.mem_data[23:16], io_wd} : dm_wd;
            end
        end
    end

    assign o_done      = done_r;
    assign o_err       = err_r;
    assign o_rdata     = rdata_r;
    assign o_reg_req   = reg_req_r;
    assign o_reg_we    = reg_we_r;
    assign o_reg_addr  = reg_addr_r;
    assign o_reg_be    = reg_be_r;
    assign o_reg_wdata = reg_wdata_r;
    assign o_mem_req   = mem_req_r;
    assign o_mem_we    = mem_we_r;
    assign o_mem_core  = mem_core_r;
    assign o_mem_wide  = mem_wide_r;
    assign o_mem_addr  = mem_addr_r;
    assign o_mem_wdata = mem_wdata_r;

endmodule : pti_target

// *** design/pti_pkg.sv ***
// shared constants and types for the pci target access path
package pti_pkg;

    localparam int          PTI_NUM_FUNC    = 3;
    localparam logic [1:0]  PTI_FUNC_LAST   = 2'h2;

    // window numbers carried on the decoded request
    localparam logic [2:0]  PTI_WIN_CTRL    = 3'h1;
    localparam logic [2:0]  PTI_WIN_MEM24   = 3'h2;
    localparam logic [2:0]  PTI_WIN_MEM16   = 3'h3;
    localparam logic [2:0]  PTI_WIN_IO      = 3'h4;

    // memory windows: word address bits and the half-select bit
    localparam int          PTI_MEM_WLSB    = 2;
    localparam int          PTI_MEM_HALF    = 18;

    // byte-enable patterns
    localparam logic [3:0]  PTI_BE_FULL     = 4'hF;
    localparam logic [3:0]  PTI_BE_LO16     = 4'h3;
    localparam logic [3:0]  PTI_BE_HI16     = 4'hC;

    // io window halfword indexes: {addr[3:2], upper lane}
    localparam logic [2:0]  PTI_IO_REG_ADDR = 3'h0;
    localparam logic [2:0]  PTI_IO_REG_DATA = 3'h1;
    localparam logic [2:0]  PTI_IO_MEM_ADDR = 3'h2;
    localparam logic [2:0]  PTI_IO_MEM_CTRL = 3'h3;
    localparam logic [2:0]  PTI_IO_MEM_DLO  = 3'h4;
    localparam logic [2:0]  PTI_IO_MEM_DHI  = 3'h5;

    // field positions
    localparam int          PTI_RA_DIR_BIT  = 15;
    localparam int          PTI_MC_WE_BIT   = 0;
    localparam int          PTI_MC_WIDE_BIT = 1;
    localparam int          PTI_MC_CORE_BIT = 2;

    // reset values
    localparam logic [15:0] PTI_RST_HW      = 16'h0000;
    localparam logic [23:0] PTI_RST_MDATA   = 24'h000000;
    localparam logic [31:0] PTI_RST_WORD    = 32'h00000000;

    typedef struct packed {
        logic [1:0]  func;
        logic [2:0]  win;
        logic        is_io;
        logic        write;
        logic [23:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pti_req_t;

    typedef struct packed {
        logic        reg_dir;
        logic [14:0] reg_addr;
        logic [15:0] reg_data;
        logic [15:0] mem_addr;
        logic        mem_we;
        logic        mem_wide;
        logic        mem_core;
        logic [23:0] mem_data;
    } pti_io_st_t;

    typedef struct packed {
        logic [1:0]  func;
        logic        io;
        logic        hi;
        logic        wide;
        logic        rd;
    } pti_cur_t;

    typedef enum logic [3:0] {
        PTI_ST_IDLE = 4'b0001,
        PTI_ST_REG  = 4'b0010,
        PTI_ST_MEM  = 4'b0100,
        PTI_ST_CAP  = 4'b1000
    } pti_state_t;

endpackage : pti_pkg

// *** design/pti_io_regs.sv ***
// indirect address and data registers of one function's io window
`timescale 1ns/100ps
module pti_io_regs
    import pti_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wr,
    input  wire logic [2:0]  i_idx,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_ld_reg,
    input  wire logic [15:0] i_reg_val,
    input  wire logic        i_ld_mem,
    input  wire logic [23:0] i_mem_val,
    output pti_io_st_t       o_st,
    output logic      [15:0] o_rd16
);

    pti_io_st_t st_r;
    pti_io_st_t st_nxt;

    wire w_ra = i_wr && (i_idx == PTI_IO_REG_ADDR);
    wire w_rd = i_wr && (i_idx == PTI_IO_REG_DATA);
    wire w_ma = i_wr && (i_idx == PTI_IO_MEM_ADDR);
    wire w_mc = i_wr && (i_idx == PTI_IO_MEM_CTRL);
    wire w_dl = i_wr && (i_idx == PTI_IO_MEM_DLO);
    wire w_dh = i_wr && (i_idx == PTI_IO_MEM_DHI);

    always_comb begin
        st_nxt = st_r;
        if (w_ra) begin
            st_nxt.reg_dir  = i_wdata[PTI_RA_DIR_BIT];
            st_nxt.reg_addr = i_wdata[14:0];
        end
        if (w_rd) begin
            st_nxt.reg_data = i_wdata;
        end
        if (i_ld_reg) begin
            st_nxt.reg_data = i_reg_val;
        end
        if (w_ma) begin
            st_nxt.mem_addr = i_wdata;
        end
        if (w_mc) begin
            st_nxt.mem_we   = i_wdata[PTI_MC_WE_BIT];
            st_nxt.mem_wide = i_wdata[PTI_MC_WIDE_BIT];
            st_nxt.mem_core = i_wdata[PTI_MC_CORE_BIT];
        end
        if (w_dl) begin
            st_nxt.mem_data[15:0] = i_wdata;
        end
        if (w_dh) begin
            st_nxt.mem_data[23:16] = i_wdata[7:0];
        end
        if (i_ld_mem) begin
            st_nxt.mem_data = i_mem_val;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r <= '{reg_dir: 1'b0, reg_addr: 15'h0000, reg_data: PTI_RST_HW,
                      mem_addr: PTI_RST_HW, mem_we: 1'b0, mem_wide: 1'b0,
                      mem_core: 1'b0, mem_data: PTI_RST_MDATA};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_st = st_r;

    always_comb begin
        case (i_idx)
            PTI_IO_REG_ADDR: o_rd16 = {st_r.reg_dir, st_r.reg_addr};
            PTI_IO_REG_DATA: o_rd16 = st_r.reg_data;
            PTI_IO_MEM_ADDR: o_rd16 = st_r.mem_addr;
            PTI_IO_MEM_CTRL: o_rd16 = {13'h0000, st_r.mem_core, st_r.mem_wide, st_r.mem_we};
            PTI_IO_MEM_DLO:  o_rd16 = st_r.mem_data[15:0];
            PTI_IO_MEM_DHI:  o_rd16 = {8'h00, st_r.mem_data[23:16]};
            default:         o_rd16 = PTI_RST_HW;
        endcase
    end

endmodule : pti_io_regs

// *** tb/pti_target_checker.sv ***
// assertion checker for the pci target access path
`timescale 1ns/100ps
module pti_target_checker
    import pti_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_req_valid,
    input  wire pti_req_t    i_req,
    input  wire logic        o_done,
    input  wire logic        o_err,
    input  wire logic        o_reg_req,
    input  wire logic        o_reg_we,
    input  wire logic [15:0] o_reg_addr,
    input  wire logic        i_reg_ack,
    input  wire logic        o_mem_req,
    input  wire logic        o_mem_core,
    input  wire logic        o_mem_wide,
    input  wire logic [15:0] o_mem_addr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire mem_win  = !i_req.is_io && (i_req.win == PTI_WIN_MEM24 || i_req.win == PTI_WIN_MEM16);
    wire byte_bad = !(i_req.be == PTI_BE_FULL || i_req.be == PTI_BE_LO16
                      || i_req.be == PTI_BE_HI16);
    wire io_bad   = i_req.is_io && !(i_req.be == PTI_BE_LO16 || i_req.be == PTI_BE_HI16);

    AST_DONE_PULSE: assert property (o_done |=> !o_done)
        else $error("completion longer than one cycle");
    AST_MEM_PULSE: assert property (o_mem_req |=> !o_mem_req)
        else $error("memory transfer longer than one cycle");
    AST_MEM_DONE: assert property (o_mem_req && mem_win |-> ##2 (o_done && !o_err))
        else $error("memory completion not two cycles after transfer");
    AST_REG_HOLD: assert property (o_reg_req && !i_reg_ack |=>
        o_reg_req && $stable(o_reg_addr))
        else $error("register request dropped or changed before ack");
    AST_REG_DONE: assert property (o_reg_req && i_reg_ack |=> o_done && !o_reg_req)
        else $error("no completion after register ack");
    AST_CTRL_MAP: assert property (o_reg_req && !i_req.is_io |->
        o_reg_addr == i_req.addr[15:0] && o_reg_we == i_req.write)
        else $error("control window address or direction wrong");
    AST_MEM_SEL: assert property (o_mem_req && mem_win |->
        o_mem_wide == (i_req.win == PTI_WIN_MEM24) && o_mem_core == i_req.addr[PTI_MEM_HALF]
        && o_mem_addr == i_req.addr[17:2])
        else $error("memory window selection wrong");
    AST_BYTE_REFUSE: assert property (i_req_valid && mem_win && byte_bad |-> !o_mem_req)
        else $error("byte access reached core memory");
    AST_IO_WIDTH: assert property ($rose(i_req_valid) && io_bad |=> o_done && o_err)
        else $error("wide io request not refused");
endmodule : pti_target_checker

bind pti_target pti_target_checker pti_target_checker_inst (.*);

// *** tb/pti_side_model.sv ***
// control register bus and core memory responder with optional slow ack
`timescale 1ns/100ps
module pti_side_model (
    input  wire logic        i_clk,
    input  wire logic        i_slow,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [15:0] i_addr,
    input  wire logic [3:0]  i_be,
    input  wire logic [31:0] i_wdata,
    output logic             o_ack,
    output logic      [31:0] o_rdata,
    input  wire logic        i_mreq,
    input  wire logic        i_mwe,
    input  wire logic        i_mcore,
    input  wire logic        i_mwide,
    input  wire logic [15:0] i_maddr,
    input  wire logic [23:0] i_mwdata,
    output logic      [23:0] o_mrdata
);
    logic [31:0] regs [16];
    logic [23:0] mem  [2][2][16];
    int          wait_r;
    initial begin
        wait_r = 0;
        o_ack = 1'b0;
        o_rdata = 32'h00000000;
        o_mrdata = 24'h000000;
        foreach (regs[i]) regs[i] = 32'h00000000;
        foreach (mem[c, w, a]) mem[c][w][a] = 24'h000000;
    end
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata; // no stale value outside the ack cycle
        if (i_req && !o_ack) begin
            if (wait_r < (i_slow ? 3 : 0)) begin
                wait_r <= wait_r + 1;
            end else begin
                wait_r <= 0;
                o_ack <= 1'b1;
                o_rdata <= regs[i_addr[5:2]];
                for (int b = 0; b < 4; b++)
                    if (i_we && i_be[b]) regs[i_addr[5:2]][8*b+:8] <= i_wdata[8*b+:8];
            end
        end
        // one word per pulse, read data the next cycle
        o_mrdata <= ~o_mrdata;
        if (i_mreq) begin
            o_mrdata <= mem[i_mcore][i_mwide][i_maddr[3:0]];
            if (i_mwe)
                mem[i_mcore][i_mwide][i_maddr[3:0]] <= i_mwide ? i_mwdata
                                                                : {8'h00, i_mwdata[15:0]};
        end
    end
endmodule : pti_side_model

// *** tb/tb.sv ***
// self-checking testbench for the pci target access path
`timescale 1ns/100ps
module tb;
    import pti_pkg::*;
    logic i_clk, i_rst_n, req_valid, slow, o_done, o_err, reg_req, reg_we, reg_ack;
    logic mem_req, mem_we, mem_core, mem_wide;
    logic [31:0] o_rdata, reg_wdata, reg_rdata, rd;
    logic [15:0] reg_addr, mem_addr;
    logic [3:0]  reg_be;
    logic [23:0] mem_wdata, mem_rdata;
    logic        er;
    pti_req_t    req;
    int          failures, total_checks;

    pti_target pti_target_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(req_valid),
        .i_req(req), .o_done(o_done), .o_err(o_err), .o_rdata(o_rdata), .o_reg_req(reg_req),
        .o_reg_we(reg_we), .o_reg_addr(reg_addr), .o_reg_be(reg_be), .o_reg_wdata(reg_wdata),
        .i_reg_ack(reg_ack), .i_reg_rdata(reg_rdata), .o_mem_req(mem_req), .o_mem_we(mem_we),
        .o_mem_core(mem_core), .o_mem_wide(mem_wide), .o_mem_addr(mem_addr),
        .o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata));
    pti_side_model pti_side_model_inst (.i_clk(i_clk), .i_slow(slow), .i_req(reg_req),
        .i_we(reg_we), .i_addr(reg_addr), .i_be(reg_be), .i_wdata(reg_wdata), .o_ack(reg_ack),
        .o_rdata(reg_rdata), .i_mreq(mem_req), .i_mwe(mem_we), .i_mcore(mem_core),
        .i_mwide(mem_wide), .i_maddr(mem_addr), .i_mwdata(mem_wdata), .o_mrdata(mem_rdata));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one host request, held until completion, result in rd and er
    task automatic op(input logic [1:0] f, input logic [2:0] w, input logic io, input logic wr,
                      input logic [23:0] a, input logic [3:0] be, input logic [31:0] wd);
        int n;
        n = 0;
        @(negedge i_clk);
        req = '{func: f, win: w, is_io: io, write: wr, addr: a, be: be, wdata: wd};
        req_valid = 1'b1;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_done !== 1'b1 && n < 40);
        if (n >= 40) begin
            failures++;
            $display("ERROR %0t: no completion", $time);
            test_done();
        end
        rd = o_rdata;
        er = o_err;
        req_valid = 1'b0;
    endtask : op

    task automatic t_ctrl;
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            for (int f = 0; f < 3; f++) begin
                op(f[1:0], PTI_WIN_CTRL, 1'b0, 1'b1, 24'(4*f), PTI_BE_FULL, 32'hC0DE0000 + f + s);
                op(f[1:0], PTI_WIN_CTRL, 1'b0, 1'b0, 24'(4*f), PTI_BE_FULL, 32'h00000000);
                chk(rd, 32'hC0DE0000 + f + s);
                chk({31'h0, er}, 32'h00000000);
            end
        end
        op(2'h0, PTI_WIN_CTRL, 1'b1, 1'b0, 24'h000000, PTI_BE_LO16, 32'h00000000);
        chk({31'h0, er}, 32'h00000001);
        // only three functions exist; a fourth is refused
        op(2'h3, PTI_WIN_CTRL, 1'b0, 1'b0, 24'h000000, PTI_BE_FULL, 32'h00000000);
        chk({31'h0, er}, 32'h00000001);
    endtask : t_ctrl

    task automatic t_mem;
        logic [23:0] a;
        for (int i = 0; i < 4; i++) begin
            a = {5'h00, i[0], 13'h0000, 5'h0C};
            op(2'h0, i[1] ? PTI_WIN_MEM16 : PTI_WIN_MEM24, 1'b0, 1'b1, a, PTI_BE_FULL,
               32'hA5C35A70 + i);
        end
        for (int i = 0; i < 4; i++) begin
            a = {5'h00, i[0], 13'h0000, 5'h0C};
            op(2'h0, i[1] ? PTI_WIN_MEM16 : PTI_WIN_MEM24, 1'b0, 1'b0, a, PTI_BE_FULL, 0);
            chk(rd, i[1] ? 32'h00005A70 + i : 32'h00C35A70 + i);
        end
        // a byte-wide write must be refused and leave the word alone
        op(2'h1, PTI_WIN_MEM24, 1'b0, 1'b1, 24'h00000C, 4'h2, 32'hFFFFFFFF);
        chk({31'h0, er}, 32'h00000001);
        op(2'h1, PTI_WIN_MEM24, 1'b0, 1'b0, 24'h00000C, PTI_BE_FULL, 0);
        chk(rd, 32'h00C35A70);
    endtask : t_mem

    task automatic t_io_reg;
        op(2'h1, PTI_WIN_IO, 1'b1, 1'b1, 24'h0, PTI_BE_LO16, {2{16'h8012}});
        op(2'h1, PTI_WIN_IO, 1'b1, 1'b1, 24'h0, PTI_BE_HI16, {2{16'hBEEF}});
        op(2'h0, PTI_WIN_CTRL, 1'b0, 1'b0, 24'h000010, PTI_BE_FULL, 0);
        chk(rd, 32'hBEEF0000);
        op(2'h0, PTI_WIN_CTRL, 1'b0, 1'b1, 24'h000010, PTI_BE_FULL, 32'h4321ABCD);
        op(2'h1, PTI_WIN_IO, 1'b1, 1'b1, 24'h0, PTI_BE_LO16, {2{16'h0012}});
        op(2'h1, PTI_WIN_IO, 1'b1, 1'b0, 24'h0, PTI_BE_HI16, 0);
        chk(rd, {2{16'h4321}});
        op(2'h2, PTI_WIN_IO, 1'b1, 1'b0, 24'h0, PTI_BE_LO16, 0);
        chk(rd, 32'h00000000);
        op(2'h1, PTI_WIN_IO, 1'b1, 1'b0, 24'h0, PTI_BE_FULL, 0);
        chk({31'h0, er}, 32'h00000001);
    endtask : t_io_reg

    task automatic t_io_mem;
        op(2'h0, PTI_WIN_IO, 1'b1, 1'b1, 24'h4, PTI_BE_LO16, {2{16'h0005}});
        op(2'h0, PTI_WIN_IO, 1'b1, 1'b1, 24'h4, PTI_BE_HI16, {2{16'h0007}});
        op(2'h0, PTI_WIN_IO, 1'b1, 1'b1, 24'h8, PTI_BE_HI16, {2{16'h005A}});
        op(2'h0, PTI_WIN_IO, 1'b1, 1'b1, 24'h8, PTI_BE_LO16, {2{16'h1234}});
        op(2'h0, PTI_WIN_MEM24, 1'b0, 1'b0, 24'h040014, PTI_BE_FULL, 0);
        chk(rd, 32'h005A1234);
        op(2'h0, PTI_WIN_MEM24, 1'b0, 1'b1, 24'h040014, PTI_BE_FULL, 32'h00C39E4F);
        op(2'h0, PTI_WIN_IO, 1'b1, 1'b1, 24'h4, PTI_BE_HI16, {2{16'h0006}});
        op(2'h0, PTI_WIN_IO, 1'b1, 1'b0, 24'h8, PTI_BE_LO16, 0);
        chk(rd, {2{16'h9E4F}});
        op(2'h0, PTI_WIN_IO, 1'b1, 1'b0, 24'h8, PTI_BE_HI16, 0);
        chk(rd, {2{16'h00C3}});
        op(2'h0, PTI_WIN_IO, 1'b1, 1'b1, 24'h4, PTI_BE_HI16, {2{16'h0001}});
        op(2'h0, PTI_WIN_IO, 1'b1, 1'b1, 24'h8, PTI_BE_LO16, {2{16'h7788}});
        op(2'h0, PTI_WIN_MEM16, 1'b0, 1'b0, 24'h000014, PTI_BE_FULL, 0);
        chk(rd, 32'h00007788);
    endtask : t_io_mem

    initial begin
        failures = 0;
        total_checks = 0;
        slow = 1'b0;
        req_valid = 1'b0;
        req = '0;
        i_rst_n = 1'b0;
        repeat (12) @(negedge i_clk);
        chk({28'h0, o_done, o_err, reg_req, mem_req}, 32'h00000000);
        chk(o_rdata, 32'h00000000);
        i_rst_n = 1'b1;
        t_ctrl();
        t_mem();
        t_io_reg();
        t_io_mem();
        test_done();
    end
endmodule : tb
